// >>> logic/cfg_access_cfg.svh
// Constants for the configuration message interpreter
`ifndef CFG_ACCESS_CFG_SVH
`define CFG_ACCESS_CFG_SVH
`define TOK_WRITE 8'hc0
`define TOK_READ 8'hc1
`define TOK_PREAD 8'h25
`define TOK_PWRITE 8'h24
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NACK 8'h04
`define NOREPLY_BYTE 8'hff
`define PS_RES_LOW 8'h0b
`define PS_SHIFT 8
`define FIFO_DEPTH 16
`define REG_COUNT 16
`endif

// >>> logic/cfg_access_pkg.sv
// Types shared by the configuration message interpreter
package cfg_access_pkg;
    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } token_t;
    typedef enum logic [3:0] {
        ST_OP = 4'h0,
        ST_RET = 4'h1,
        ST_REG = 4'h2,
        ST_SIZE = 4'h3,
        ST_DATA = 4'h4,
        ST_END = 4'h5,
        ST_DRAIN = 4'h6,
        ST_HDR = 4'h7,
        ST_RDATA = 4'h8,
        ST_TAIL = 4'h9
    } state_t;
endpackage

// >>> logic/tok_fifo.sv
// Token FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tok_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
    assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
    // Storage needs no reset; empty entries are never shown as valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// >>> logic/cfg_access.sv
// Configuration message interpreter: decodes request tokens, accesses registers, replies
`timescale 1ns/1ps
`default_nettype none
`include "cfg_access_cfg.svh"
module cfg_access (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cfg_access_pkg::token_t rx_tok_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output var cfg_access_pkg::token_t tx_tok_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [23:0] reply_dest_o,
    input wire logic [7:0] ps_reg_i,
    output logic [15:0] ps_res_id_o
);
    localparam int NREG = `REG_COUNT;
    localparam int AW = $clog2(NREG);
    cfg_access_pkg::state_t st_q, st_d;
    cfg_access_pkg::token_t ftok;
    logic fvalid, fready;
    logic [7:0] op_q, op_d;
    logic [23:0] ret_q, ret_d;
    // Reply address is latched at launch, so a stalled end token keeps its own address
    logic [23:0] dest_q, dest_d;
    logic [15:0] reg_q, reg_d;
    logic [7:0] size_q, size_d;
    logic [31:0] wdat_q, wdat_d;
    logic [7:0] cnt_q, cnt_d;
    logic bad_q, bad_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] regs_q [NREG];
    logic [7:0] pregs_q [NREG];
    logic wr_tile, wr_per;
    logic [AW-1:0] widx;
    logic [7:0] wbyte;
    cfg_access_pkg::token_t otok_q, otok_d;
    logic ovalid_q, ovalid_d;
    logic take, out_free;
    logic ok, is_per, in_range;

    tok_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH)) tok_fifo_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(rx_tok_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .out_data_o(ftok),
        .out_valid_o(fvalid),
        .out_ready_i(fready)
    );

    assign ps_res_id_o = {ps_reg_i, `PS_RES_LOW};
    assign tx_tok_o = otok_q;
    assign tx_valid_o = ovalid_q;
    assign reply_dest_o = dest_q;

    always_comb begin
        out_free = !ovalid_q || tx_ready_i;
        is_per = op_q == `TOK_PREAD || op_q == `TOK_PWRITE;
        in_range = is_per ? (reg_q[7:0] < 8'(NREG)) : (reg_q < 16'(NREG));
        ok = !bad_q && in_range;
        fready = 1'b0;
        st_d = st_q;
        op_d = op_q;
        ret_d = ret_q;
        dest_d = dest_q;
        reg_d = reg_q;
        size_d = size_q;
        wdat_d = wdat_q;
        cnt_d = cnt_q;
        bad_d = bad_q;
        rdat_d = rdat_q;
        otok_d = otok_q;
        ovalid_d = ovalid_q && !tx_ready_i;
        wr_tile = 1'b0;
        wr_per = 1'b0;
        widx = reg_q[AW-1:0];
        wbyte = ftok.data;
        take = 1'b0;
        case (st_q)
            cfg_access_pkg::ST_OP: begin
                fready = 1'b1;
                if (fvalid) begin
                    op_d = ftok.data;
                    cnt_d = 8'h00;
                    ret_d = 24'h000000;
                    reg_d = 16'h0000;
                    size_d = 8'h00;
                    bad_d = !ftok.ctrl || !(ftok.data == `TOK_WRITE || ftok.data == `TOK_READ
                        || ftok.data == `TOK_PREAD || ftok.data == `TOK_PWRITE);
                    st_d = cfg_access_pkg::ST_RET;
                    if (ftok.ctrl && ftok.data == `TOK_END) begin
                        st_d = cfg_access_pkg::ST_HDR;
                    end
                end
            end
            cfg_access_pkg::ST_RET, cfg_access_pkg::ST_REG, cfg_access_pkg::ST_SIZE,
            cfg_access_pkg::ST_DATA, cfg_access_pkg::ST_END: begin
                fready = 1'b1;
                take = fvalid;
            end
            cfg_access_pkg::ST_DRAIN: begin
                fready = 1'b1;
                if (fvalid && ftok.ctrl && ftok.data == `TOK_END) begin
                    st_d = cfg_access_pkg::ST_HDR;
                end
            end
            cfg_access_pkg::ST_HDR: begin
                if (ok && op_q == `TOK_WRITE) begin
                    wr_tile = 1'b1;
                end
                if (ok && op_q == `TOK_READ) begin
                    rdat_d = regs_q[widx];
                end
                if (ret_q[7:0] == `NOREPLY_BYTE && ok
                    && (op_q == `TOK_WRITE || op_q == `TOK_PWRITE)) begin
                    st_d = cfg_access_pkg::ST_OP;
                end else if (out_free) begin
                    otok_d = '{ctrl: 1'b1, data: ok ? `TOK_ACK : `TOK_NACK};
                    ovalid_d = 1'b1;
                    dest_d = ret_q;
                    cnt_d = 8'h00;
                    st_d = (ok && op_q == `TOK_READ) || (ok && op_q == `TOK_PREAD && size_q != 8'h00)
                        ? cfg_access_pkg::ST_RDATA : cfg_access_pkg::ST_TAIL;
                end
            end
            cfg_access_pkg::ST_RDATA: begin
                if (out_free) begin
                    ovalid_d = 1'b1;
                    cnt_d = cnt_q + 8'h01;
                    if (op_q == `TOK_READ) begin
                        otok_d = '{ctrl: 1'b0, data: rdat_q[31:24]};
                        rdat_d = {rdat_q[23:0], 8'h00};
                        if (cnt_q == 8'h03) begin
                            st_d = cfg_access_pkg::ST_TAIL;
                        end
                    end else begin
                        otok_d = '{ctrl: 1'b0, data: pregs_q[AW'(reg_q[7:0] + cnt_q)]};
                        if (cnt_q + 8'h01 == size_q) begin
                            st_d = cfg_access_pkg::ST_TAIL;
                        end
                    end
                end
            end
            cfg_access_pkg::ST_TAIL: begin
                if (out_free) begin
                    otok_d = '{ctrl: 1'b1, data: `TOK_END};
                    ovalid_d = 1'b1;
                    st_d = cfg_access_pkg::ST_OP;
                end
            end
            default: st_d = cfg_access_pkg::ST_OP;
        endcase
        // Field collection; a control token mid-field marks the message short
        if (take) begin
            cnt_d = cnt_q + 8'h01;
            if (ftok.ctrl) begin
                // Only the closing token in the end slot is a clean finish
                if (st_q != cfg_access_pkg::ST_END || ftok.data != `TOK_END) begin
                    bad_d = 1'b1;
                end
                st_d = ftok.data == `TOK_END ? cfg_access_pkg::ST_HDR : cfg_access_pkg::ST_DRAIN;
            end else begin
                case (st_q)
                    cfg_access_pkg::ST_RET: begin
                        ret_d = {ret_q[15:0], ftok.data};
                        if (cnt_q == 8'h02) begin
                            cnt_d = 8'h00;
                            st_d = cfg_access_pkg::ST_REG;
                        end
                    end
                    cfg_access_pkg::ST_REG: begin
                        reg_d = {reg_q[7:0], ftok.data};
                        if (is_per) begin
                            cnt_d = 8'h00;
                            st_d = cfg_access_pkg::ST_SIZE;
                        end else if (cnt_q == 8'h01) begin
                            cnt_d = 8'h00;
                            st_d = op_q == `TOK_WRITE ? cfg_access_pkg::ST_DATA
                                : cfg_access_pkg::ST_END;
                        end
                    end
                    cfg_access_pkg::ST_SIZE: begin
                        size_d = ftok.data;
                        cnt_d = 8'h00;
                        st_d = (op_q == `TOK_PWRITE && ftok.data != 8'h00)
                            ? cfg_access_pkg::ST_DATA : cfg_access_pkg::ST_END;
                    end
                    cfg_access_pkg::ST_DATA: begin
                        if (op_q == `TOK_PWRITE) begin
                            wr_per = reg_q[7:0] + cnt_q < 8'(NREG);
                            widx = AW'(reg_q[7:0] + cnt_q);
                            if (cnt_q + 8'h01 == size_q) begin
                                st_d = cfg_access_pkg::ST_END;
                            end
                        end else begin
                            wdat_d = {wdat_q[23:0], ftok.data};
                            if (cnt_q == 8'h03) begin
                                st_d = cfg_access_pkg::ST_END;
                            end
                        end
                    end
                    default: begin
                        bad_d = 1'b1;
                        st_d = cfg_access_pkg::ST_DRAIN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= cfg_access_pkg::ST_OP;
            op_q <= 8'h00;
            ret_q <= 24'h000000;
            dest_q <= 24'h000000;
            reg_q <= 16'h0000;
            size_q <= 8'h00;
            wdat_q <= 32'h00000000;
            cnt_q <= 8'h00;
            bad_q <= 1'b0;
            rdat_q <= 32'h00000000;
            otok_q <= '0;
            ovalid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            ret_q <= ret_d;
            dest_q <= dest_d;
            reg_q <= reg_d;
            size_q <= size_d;
            wdat_q <= wdat_d;
            cnt_q <= cnt_d;
            bad_q <= bad_d;
            rdat_q <= rdat_d;
            otok_q <= otok_d;
            ovalid_q <= ovalid_d;
        end
    end

    // Register banks, one generate iteration per entry
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                regs_q[i] <= 32'h00000000;
                pregs_q[i] <= 8'h00;
            end else begin
                if (wr_tile && widx == AW'(i)) begin
                    regs_q[i] <= wdat_q;
                end
                if (wr_per && widx == AW'(i)) begin
                    pregs_q[i] <= wbyte;
                end
            end
        end
    end

    ps_id_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ps_res_id_o[7:0] == 8'h0b && ps_res_id_o[15:8] == ps_reg_i)
        else $error("status resource id wrong");
    tail_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_TAIL && out_free |=> tx_valid_o && tx_tok_o.ctrl
        && tx_tok_o.data == 8'h01)
        else $error("reply not closed by end token");
    nack_nodata_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_HDR && !ok && out_free
        |=> tx_tok_o.data == 8'h04 ##0 st_q == cfg_access_pkg::ST_TAIL)
        else $error("failure reply carries data");
    read_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_HDR && ok && op_q == 8'hc1 && out_free
        |=> tx_tok_o.data == 8'h03 && st_q == cfg_access_pkg::ST_RDATA)
        else $error("read reply does not start data");
    // An earlier end token may still be waiting; only a new token is forbidden
    noreply_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_HDR && ok && op_q == 8'hc0 && ret_q[7:0] == 8'hff
        |=> st_q == cfg_access_pkg::ST_OP && !$rose(tx_valid_o) && $stable(tx_tok_o))
        else $error("suppressed write replied");
    ret_msb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_RET && take && !ftok.ctrl
        |=> ret_q[7:0] == $past(ftok.data))
        else $error("return id not shifted msb first");
    bad_op_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_OP && fvalid && (!ftok.ctrl || !(ftok.data == 8'hc0
        || ftok.data == 8'hc1 || ftok.data == 8'h24 || ftok.data == 8'h25)) |=> bad_q)
        else $error("unknown opener not failed");
    per_size_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == cfg_access_pkg::ST_REG && take && !ftok.ctrl && is_per
        |=> st_q == cfg_access_pkg::ST_SIZE)
        else $error("peripheral register not one byte");
endmodule
`default_nettype wire

// >>> dv/cfg_requester.sv
// Requesting channel-end model: sends request messages, paces replies
`timescale 1ns/1ps
`default_nettype none
module cfg_requester (
    input wire logic clk_i,
    input wire logic rst_i,
    output var cfg_access_pkg::token_t tok_o,
    output logic valid_o,
    input wire logic ready_i,
    input wire logic hold_i,
    output logic accept_o,
    output logic saw_full_o,
    output logic stuck_o
);
    initial begin
        tok_o = '0;
        valid_o = 1'b0;
        accept_o = 1'b0;
        saw_full_o = 1'b0;
        stuck_o = 1'b0;
    end
    // Readiness moves on the falling edge, so a slow sink never races the sampler
    always @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            accept_o <= 1'b0;
        end else begin
            accept_o <= !hold_i;
        end
    end
    // Token held until an edge that sees ready high; ready only moves on edges
    task automatic put(input logic c, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_i);
        tok_o = {c, d};
        valid_o = 1'b1;
        while (ready_i !== 1'b1 && n < 2000) begin
            saw_full_o = 1'b1;
            @(negedge clk_i);
            n++;
        end
        if (n >= 2000) stuck_o = 1'b1;
    endtask
    task automatic word(input logic [31:0] w, input int nb);
        for (int i = nb - 1; i >= 0; i--) put(1'b0, w[8*i+:8]);
    endtask
    // Opener, return id, register field, data, closing token
    task automatic msg(input logic [7:0] op, input logic [23:0] r,
                       input logic [31:0] a, input int na, input logic [31:0] d, input int nd);
        put(1'b1, op);
        word({8'h00, r}, 3);
        word(a, na);
        word(d, nd);
        put(1'b1, 8'h01);
    endtask
    // Destination word a requester programs; the decode of it sits upstream
    function automatic logic [31:0] route(input logic [1:0] kind, input logic [15:0] node,
                                          input logic [7:0] per);
        case (kind)
            2'h0: return {node, 16'hc20c};
            2'h1: return {node, 16'hc30c};
            default: return {node, per, 8'h02};
        endcase
    endfunction
    task automatic idle();
        @(negedge clk_i);
        valid_o = 1'b0;
        tok_o = ~tok_o;
    endtask
endmodule
`default_nettype wire

// >>> dv/cfg_access_tb.sv
// Self-checking bench for the configuration message interpreter
`timescale 1ns/1ps
`default_nettype none
module cfg_access_tb;
    typedef struct packed {
        cfg_access_pkg::token_t tok;
        logic chk;
        logic [23:0] rid;
    } exp_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cfg_access_pkg::token_t rx_tok, tx_tok;
    logic rx_valid, rx_ready, tx_valid, tx_ready, saw_full, stuck;
    logic hold = 1'b0;
    logic [23:0] reply_dest;
    logic [7:0] ps_reg = 8'h00;
    logic [15:0] ps_res_id;
    logic [31:0] lfsr_q = 32'h76f4;
    logic [31:0] rm [16];
    logic [7:0] pm [16];
    exp_t exp_q[$];
    exp_t e;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pace = 0;
    cfg_access cfg_access_i (
        .clk_i(clk_i), .rst_i(rst_i), .rx_tok_i(rx_tok), .rx_valid_i(rx_valid),
        .rx_ready_o(rx_ready), .tx_tok_o(tx_tok), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .reply_dest_o(reply_dest), .ps_reg_i(ps_reg),
        .ps_res_id_o(ps_res_id));
    cfg_requester cfg_requester_i (
        .clk_i(clk_i), .rst_i(rst_i), .tok_o(rx_tok), .valid_o(rx_valid),
        .ready_i(rx_ready), .hold_i(hold), .accept_o(tx_ready),
        .saw_full_o(saw_full), .stuck_o(stuck));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic fail(input string m);
        failures++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic give_verdict();
        if (stuck !== 1'b0) fail("request stalled");
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Sink stalls at random in pace 1 and holds off entirely in pace 2
    always @(negedge clk_i) begin
        lfsr_q = lfsr_next(lfsr_q);
        hold <= (pace == 2) || (pace == 1 && lfsr_q[5]);
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fail("timeout");
            give_verdict();
        end
    end
    task automatic reply(input logic ok, input logic [23:0] r, input logic [31:0] d,
                         input int nb, input logic c);
        exp_q.push_back({ok ? 9'h103 : 9'h104, c, r});
        for (int i = nb - 1; i >= 0; i--) exp_q.push_back({1'b0, d[8*i+:8], c, r});
        exp_q.push_back({9'h101, c, r});
    endtask
    task automatic wr(input logic [23:0] r, input logic [15:0] a, input logic [31:0] d);
        logic ok;
        ok = a < 16;
        if (ok) rm[a[3:0]] = d;
        if (!ok || r[7:0] != 8'hff) reply(ok, r, 0, 0, 1'b1);
        cfg_requester_i.msg(8'hc0, r, {16'h0, a}, 2, d, 4);
    endtask
    task automatic rd(input logic [23:0] r, input logic [15:0] a);
        logic ok;
        ok = a < 16;
        reply(ok, r, ok ? rm[a[3:0]] : 0, ok ? 4 : 0, 1'b1);
        cfg_requester_i.msg(8'hc1, r, {16'h0, a}, 2, 0, 0);
    endtask
    task automatic pwr(input logic [23:0] r, input logic [7:0] a, input int n,
                       input logic [31:0] d);
        for (int i = 0; i < n; i++) pm[(a + i) % 16] = d[8*(n-1-i)+:8];
        if (r[7:0] != 8'hff) reply(1'b1, r, 0, 0, 1'b1);
        cfg_requester_i.msg(8'h24, r, {16'h0, a, 8'(n)}, 2, d, n);
    endtask
    task automatic prd(input logic [23:0] r, input logic [7:0] a, input int n);
        logic [31:0] d;
        d = 0;
        for (int i = 0; i < n; i++) d = {d[23:0], pm[(a + i) % 16]};
        reply(1'b1, r, d, n, 1'b1);
        cfg_requester_i.msg(8'h25, r, {16'h0, a, 8'(n)}, 2, 0, 0);
    endtask
    task automatic settle();
        int n;
        n = 0;
        cfg_requester_i.idle();
        while (exp_q.size() != 0 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 3000) fail("reply missing");
        repeat (10) @(negedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("unexpected reply token");
            end else begin
                e = exp_q.pop_front();
                samples_checked++;
                if (tx_tok !== e.tok) fail("reply token differs");
                if (e.chk && reply_dest !== e.rid) fail("return id differs");
            end
        end
    end
    initial begin
        for (int i = 0; i < 16; i++) begin
            rm[i] = 0;
            pm[i] = 0;
        end
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        wr(24'h123401, 3, 32'hdeadbeef);
        rd(24'h123402, 3);
        wr(24'h1234ff, 5, 32'h01020304);
        settle();
        if (saw_full !== 1'b0) fail("buffer refused early");
        rd(24'h123403, 5);
        rd(24'h000104, 16);
        wr(24'h0000ff, 16'h0100, 1);
        reply(1'b0, 0, 0, 0, 1'b0);
        cfg_requester_i.put(1'b1, 8'h55);
        cfg_requester_i.put(1'b1, 8'h01);
        reply(1'b0, 0, 0, 0, 1'b0);
        cfg_requester_i.put(1'b0, 8'h33);
        cfg_requester_i.put(1'b1, 8'h01);
        reply(1'b0, 24'habcdef, 0, 0, 1'b1);
        cfg_requester_i.msg(8'hc1, 24'habcdef, 0, 1, 0, 0);
        pwr(24'h005501, 13, 3, 32'haabbcc);
        prd(24'h005502, 13, 3);
        prd(24'h005503, 15, 2);
        pwr(24'h0055ff, 2, 1, 32'h77);
        settle();
        prd(24'h005504, 2, 1);
        settle();
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_i);
            ps_reg = lfsr_q[7:0];
            #1;
            samples_checked++;
            if (ps_res_id !== {ps_reg, 8'h0b}) fail("status resource id differs");
        end
        samples_checked += 3;
        if (cfg_requester_i.route(2'h0, 16'h12, 8'h0) !== 32'h0012c20c) fail("tile route");
        if (cfg_requester_i.route(2'h1, 16'h12, 8'h0) !== 32'h0012c30c) fail("node route");
        if (cfg_requester_i.route(2'h2, 16'h12, 8'h5) !== 32'h00120502) fail("periph route");
        pace = 1;
        repeat (24) begin
            wr({lfsr_q[23:8], 8'h10}, {11'h0, lfsr_q[4:0]}, lfsr_q);
            rd(24'h777701, {12'h0, lfsr_q[7:4]});
        end
        settle();
        pace = 2;
        fork
            begin
                repeat (400) @(negedge clk_i);
                pace = 1;
            end
        join_none
        repeat (4) rd(24'h888801, 7);
        settle();
        samples_checked++;
        if (saw_full !== 1'b1) fail("buffer never refused");
        pace = 0;
        give_verdict();
    end
endmodule
`default_nettype wire
